// ===== dv/tb.sv
`timescale 1ns/1ns
`include "zts_consts.svh"
module tb;
  localparam int DW = `ZTS_DATA_W;
  localparam int LN = `ZTS_LANES;
  localparam int LW = DW / LN;
  logic clock, rst_b, req_valid, req_write, req_burst, hold, linear_order, hold_en;
  logic req_ready, wr_data_take, rd_valid, r;
  logic [`ZTS_ADDR_W-1:0] req_addr;
  logic [LN-1:0] req_lanes_n, wl;
  logic [DW-1:0] wr_data, rd_data;
  logic [DW-1:0] model [16];
  logic [DW-1:0] rq[$];
  logic [3:0] wq[$], wa;
  logic mem_busy;
  logic [LN-1:0] lq[$];
  int bad_count, num_checks;
  zts_if bi (.clock(clock));
  zts_mem zts_mem_inst (.bus(bi), .rst_b(rst_b), .busy(mem_busy));
  zts_master zts_master_inst (.bus(bi), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_burst(req_burst), .req_addr(req_addr),
    .req_lanes_n(req_lanes_n), .wr_data(wr_data), .hold(hold), .linear_order(linear_order),
    .req_ready(req_ready), .wr_data_take(wr_data_take), .rd_data(rd_data), .rd_valid(rd_valid));
  zts_monitor zts_monitor_inst (.clock(clock), .rst_b(rst_b), .clock_hold_n(bi.clock_hold_n),
    .chip_select_first_n(bi.chip_select_first_n), .chip_select_second(bi.chip_select_second),
    .chip_select_third_n(bi.chip_select_third_n), .advance_or_load(bi.advance_or_load),
    .write_select_n(bi.write_select_n), .output_drive_n(bi.output_drive_n),
    .dq_oe_mem(bi.dq_oe_mem), .dq_oe_master(bi.dq_oe_master));
  // clock source
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // random stall and fresh write data each cycle
  always @(posedge clock) begin
    #1;
    hold = hold_en && ($urandom % 6 == 0);
    wr_data = DW'({$urandom, $urandom, $urandom});
  end
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_data(logic [DW-1:0] exp, logic [DW-1:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] rd_data exp %h got %h", exp, got);
    end
  endtask
  // quiet bus at the end: memory idle, nothing left outstanding
  task automatic cmp_idle(logic got);
    num_checks++;
    if (got !== 1'b0 || rq.size() != 0 || wq.size() != 0) begin
      bad_count++;
      $display("[FAIL] busy exp 0 got %b, %0d/%0d words left", got, rq.size(), wq.size());
    end
  endtask
  // address of word k of a burst in the current order
  function automatic logic [3:0] baddr(logic [3:0] a, int k);
    return linear_order ? {a[3:2], a[1:0] + 2'(k)} : {a[3:2], a[1:0] ^ 2'(k)};
  endfunction
  // present one request, wait for acceptance, note the expected words
  task automatic issue(logic w, logic b, logic [3:0] a, logic [LN-1:0] ln);
    req_valid = 1;
    req_write = w;
    req_burst = b;
    req_addr = `ZTS_ADDR_W'(a);
    req_lanes_n = ln;
    do begin
      @(negedge clock) r = req_ready;
      @(posedge clock);
    end while (r !== 1'b1);
    #1;
    for (int k = 0; k < (b ? 4 : 1); k++) begin
      if (w) begin
        wq.push_back(baddr(a, k));
        lq.push_back(ln);
      end else rq.push_back(model[baddr(a, k)]);
    end
  endtask
  // take write data into the model, check read words in order
  always @(negedge clock) begin
    if (wr_data_take === 1'b1 && wq.size() > 0) begin
      wa = wq.pop_front();
      wl = lq.pop_front();
      for (int i = 0; i < LN; i++) begin
        if (!wl[i]) model[wa][i*LW +: LW] = wr_data[i*LW +: LW];
      end
    end
    if (rd_valid === 1'b1) begin
      if (rq.size() > 0) cmp_data(rq.pop_front(), rd_data);
      else cmp_data('x, rd_data);
    end
  end
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  initial begin
    void'($urandom(32'h795b));
    {rst_b, req_valid, req_write, req_burst, hold, hold_en} = '0;
    req_addr = '0;
    req_lanes_n = '0;
    wr_data = '0;
    linear_order = 1;
    repeat (6) @(posedge clock);
    #1 rst_b = 1;
    for (int i = 0; i < 4; i++) issue(1, 1, 4'(i * 4), '0);
    hold_en = 1;
    for (int m = 0; m < 2; m++) begin
      for (int n = 0; n < 50; n++) begin
        issue($urandom % 2, $urandom % 2, 4'($urandom), LN'($urandom));
        if ($urandom % 4 == 0) begin
          req_valid = 0;
          repeat ($urandom % 3 + 1) @(posedge clock);
          #1;
        end
      end
      req_valid = 0;
      repeat (12) @(posedge clock);
      #1 linear_order = 0;
    end
    hold_en = 0;
    repeat (12) @(posedge clock);
    cmp_idle(mem_busy);
    test_done;
  end
endmodule

// ===== dv/zts_monitor.sv
`timescale 1ns/1ns
module zts_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clock_hold_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic advance_or_load,
  input wire logic write_select_n,
  input wire logic output_drive_n,
  input wire logic dq_oe_mem,
  input wire logic dq_oe_master
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic run, sel, rd, wr, ds, adv;
  // decoded command of each sampled cycle
  assign run = !clock_hold_n;
  assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign rd = run && !advance_or_load && sel && write_select_n;
  assign wr = run && !advance_or_load && sel && !write_select_n;
  assign ds = run && !advance_or_load && !sel;
  assign adv = run && advance_or_load;
  rd_lat_a: assert property (rd ##1 run |=> dq_oe_mem || output_drive_n)
    else $error("read data not driven two cycles on");
  wr_float_a: assert property (wr ##1 run |=> !dq_oe_mem)
    else $error("memory drives in a write data slot");
  desel_float_a: assert property (ds ##1 run |=> !dq_oe_mem)
    else $error("memory drives after deselect");
  wr_data_a: assert property (wr ##1 run |=> dq_oe_master)
    else $error("write data not driven two cycles on");
  oe_async_a: assert property (output_drive_n |-> !dq_oe_mem)
    else $error("memory drives while output disabled");
  bus_clash_a: assert property (!(dq_oe_mem && dq_oe_master))
    else $error("both ends drive the data bus");
  hold_freeze_a: assert property (
    clock_hold_n |=> $stable(dq_oe_mem) && $stable(dq_oe_master))
    else $error("drive changed during clock hold");
  rd_burst_a: assert property (rd ##1 adv [*3] ##1 run |=> dq_oe_mem || output_drive_n)
    else $error("read burst fourth word missing");
  wr_burst_a: assert property (wr ##1 adv [*3] ##1 run |=> dq_oe_master)
    else $error("write burst fourth word missing");
  cover property (rd ##1 wr);
  cover property (wr ##1 adv [*3]);
  cover property (clock_hold_n && dq_oe_mem);
endmodule

// ===== hdl/zts_consts.svh
`ifndef ZTS_CONSTS_SVH
`define ZTS_CONSTS_SVH
// pipeline depth from address sample to data
`define ZTS_DATA_LAT 2
// burst length in words and counter width
`define ZTS_BURST_LEN 4
`define ZTS_BURST_BITS 2
// default organisation: 512K x 36 with four byte lanes
`define ZTS_ADDR_W 19
`define ZTS_DATA_W 36
`define ZTS_LANES 4
// burst order codes on the order pin
`define ZTS_ORDER_LINEAR 1'b1
`define ZTS_ORDER_INTERLEAVED 1'b0
`endif

// ===== hdl/zts_if.sv
`timescale 1ns/1ns
`include "zts_consts.svh"
interface zts_if #(
  parameter int ADDR_W = `ZTS_ADDR_W,
  parameter int DATA_W = `ZTS_DATA_W,
  parameter int LANES = `ZTS_LANES
) (
  input wire logic clock
);
  logic [ADDR_W-1:0] address;
  logic clock_hold_n;
  logic chip_select_first_n;
  logic chip_select_second;
  logic chip_select_third_n;
  logic advance_or_load;
  logic write_select_n;
  logic [LANES-1:0] byte_lane_write_n;
  logic burst_order;
  logic output_drive_n;
  logic sleep_request;
  logic [DATA_W-1:0] dq_from_mem;
  logic dq_oe_mem;
  logic [DATA_W-1:0] dq_from_master;
  logic dq_oe_master;
  // resolved level of the shared data bus
  logic [DATA_W-1:0] dq;
  assign dq = dq_oe_mem ? dq_from_mem : (dq_oe_master ? dq_from_master : '0);
  modport mem (
    input clock, address, clock_hold_n, chip_select_first_n, chip_select_second,
    input chip_select_third_n, advance_or_load, write_select_n, byte_lane_write_n,
    input burst_order, output_drive_n, sleep_request, dq,
    output dq_from_mem, dq_oe_mem
  );
  modport master (
    input clock, dq,
    output address, clock_hold_n, chip_select_first_n, chip_select_second,
    output chip_select_third_n, advance_or_load, write_select_n, byte_lane_write_n,
    output burst_order, output_drive_n, sleep_request, dq_from_master, dq_oe_master
  );
endinterface

// ===== hdl/zts_master.sv
`timescale 1ns/1ns
`include "zts_consts.svh"
// issues single loads or bursts; write data follows two cycles later
module zts_master import zts_pkg::*; #(
  parameter int ADDR_W = `ZTS_ADDR_W,
  parameter int DATA_W = `ZTS_DATA_W,
  parameter int LANES = `ZTS_LANES
) (
  zts_if.master bus,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_burst,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [LANES-1:0] req_lanes_n,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic hold,
  input wire logic linear_order,
  output logic req_ready,
  output logic wr_data_take,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid
);
  zts_state_t state, next_state;
  logic [1:0] left, next_left;
  logic [1:0] wr_pipe, next_wr_pipe;
  logic [1:0] rd_pipe, next_rd_pipe;
  logic [DATA_W-1:0] next_rd_data;
  logic next_rd_valid;
  logic is_write, next_is_write;
  logic [DATA_W-1:0] wdata_q, next_wdata_q;
  // lanes latched at the load so every burst word uses the same lanes
  logic [LANES-1:0] lanes_q, next_lanes_q;

  assign req_ready = (state == zts_st_idle) && !hold;

  // sequencer: load on accept, advance three more for a burst
  always_comb begin
    next_state = state;
    next_left = left;
    next_is_write = is_write;
    next_wr_pipe = wr_pipe;
    next_rd_pipe = rd_pipe;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_wdata_q = wdata_q;
    next_lanes_q = lanes_q;
    if (!hold) begin  // [R03]
      next_wr_pipe = {wr_pipe[0], 1'b0};
      next_rd_pipe = {rd_pipe[0], 1'b0};
      next_rd_valid = rd_pipe[1];  // [R02]
      if (rd_pipe[1]) begin
        next_rd_data = bus.dq;
      end
      if (wr_pipe[0]) begin
        next_wdata_q = wr_data;
      end
      unique case (state)
        zts_st_idle: begin
          if (req_valid) begin
            next_is_write = req_write;
            next_lanes_q = req_lanes_n;  // [R15]
            next_wr_pipe[0] = req_write;
            next_rd_pipe[0] = !req_write;
            if (req_burst) begin
              next_state = zts_st_burst;
              next_left = 2'd3;
            end
          end
        end
        zts_st_burst: begin
          next_wr_pipe[0] = is_write;
          next_rd_pipe[0] = !is_write;
          next_left = left - 2'd1;
          if (left == 2'd1) begin
            next_state = zts_st_idle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge bus.clock) begin
    if (!rst_b) begin
      state <= zts_st_idle;
      left <= 2'd0;
      is_write <= 1'b0;
      wr_pipe <= 2'b00;
      rd_pipe <= 2'b00;
      rd_data <= '0;
      rd_valid <= 1'b0;
      wdata_q <= '0;
      lanes_q <= '1;
    end else begin
      state <= next_state;
      left <= next_left;
      is_write <= next_is_write;
      wr_pipe <= next_wr_pipe;
      rd_pipe <= next_rd_pipe;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      wdata_q <= next_wdata_q;
      lanes_q <= next_lanes_q;
    end
  end

  // pin drive: load when idle and accepted, advance in burst
  always_comb begin
    bus.clock_hold_n = hold;  // [R01]
    bus.address = req_addr;
    bus.advance_or_load = (state == zts_st_burst);  // [R09]
    bus.chip_select_first_n = !(state == zts_st_burst || req_valid);
    bus.chip_select_second = 1'b1;
    bus.chip_select_third_n = 1'b0;
    bus.write_select_n = (state == zts_st_burst) ? !is_write : !req_write;
    bus.byte_lane_write_n = (state == zts_st_burst) ? lanes_q : req_lanes_n;  // [R15]
    bus.burst_order = linear_order;
    bus.output_drive_n = 1'b0;
    bus.sleep_request = 1'b0;  // [R13]
  end

  // write data on the bus in the data phase of each write
  assign wr_data_take = wr_pipe[0] && !hold;
  assign bus.dq_from_master = wdata_q;
  assign bus.dq_oe_master = wr_pipe[1];  // [R02] [R11]
endmodule

// ===== hdl/zts_mem.sv
`timescale 1ns/1ns
`include "zts_consts.svh"
// What this block does
// R01: all synchronous inputs sampled on rising edge
// R02: data follows address by two cycles
// R03: clock hold freezes every internal register
// R04: deselect on load starts nothing, ends burst
// R05: accepted operations still finish their data
// R06: outputs float two cycles after deselect/write
// R07: two-bit counter gives four-word bursts
// R08: static order pin picks linear or interleaved
// R09: load low loads address, high advances
// R10: output drive enable floats outputs asynchronously
// R11: write select per cycle, no turnaround gaps
// R12: read data leaves through clocked registers
// R13: master ties sleep low when unused
// R14: 512Kx36 or 1Mx18, low bits count bursts
// R15: byte lanes gate writes, all low writes all
// R16: linear adds modulo four, interleaved xors count
module zts_mem import zts_pkg::*; #(
  parameter int ADDR_W = `ZTS_ADDR_W,
  parameter int DATA_W = `ZTS_DATA_W,
  parameter int LANES = `ZTS_LANES
) (
  zts_if.mem bus,
  input wire logic rst_b,
  output logic busy
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH = 1 << ADDR_W;

  // organisation checks, refused at elaboration
  if (DATA_W % LANES != 0) begin
    $error("zts_mem: lanes must split the data word evenly");
  end
  if (ADDR_W <= `ZTS_BURST_BITS) begin
    $error("zts_mem: address too narrow for the burst counter");
  end
  // the array depth is reckoned in an int, so the address stays below 31 bits
  if (ADDR_W > 30) begin
    $error("zts_mem: address too wide for the storage array");
  end

  logic [DATA_W-1:0] mem [DEPTH];  // [R14]
  // burst state
  logic [ADDR_W-1:0] base;
  logic [1:0] count;
  logic active;
  logic burst_write;
  logic [1:0] next_count;
  logic next_active;
  logic [ADDR_W-1:0] next_base;
  logic next_burst_write;
  // first pipeline stage: operation, address and lanes as sampled
  zts_op_t op1;
  zts_op_t next_op1;
  logic [ADDR_W-1:0] addr1;
  logic [ADDR_W-1:0] next_addr1;
  logic [LANES-1:0] lanes1;
  logic [LANES-1:0] next_lanes1;
  // second pipeline stage: the data phase
  zts_op_t op2;
  zts_op_t next_op2;
  logic [ADDR_W-1:0] addr2;
  logic [ADDR_W-1:0] next_addr2;
  logic [LANES-1:0] lanes2;
  logic [LANES-1:0] next_lanes2;
  // read output register and its bus drive
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic drive;
  logic next_drive;
  // read word with a write in its data phase merged in
  logic [DATA_W-1:0] fwd_word;
  // chip decode and the address of the current burst word
  logic selected;
  logic [1:0] low_bits;
  logic [ADDR_W-1:0] cur_addr;

  assign selected = !bus.chip_select_first_n && bus.chip_select_second
    && !bus.chip_select_third_n;

  // burst sequencing and first pipeline stage
  always_comb begin
    next_base = base;
    next_count = count;
    next_active = active;
    next_burst_write = burst_write;
    next_op1 = op1;
    next_addr1 = addr1;
    next_lanes1 = lanes1;
    low_bits = 2'b00;
    cur_addr = base;
    if (bus.clock_hold_n == 1'b0) begin  // [R03] [R01]
      if (!bus.advance_or_load) begin  // [R09]
        // a load restarts the counter, selected or not
        next_count = 2'b00;
        if (selected) begin
          next_base = bus.address;
          next_active = 1'b1;
          next_burst_write = !bus.write_select_n;  // [R11]
          next_op1 = bus.write_select_n ? zts_op_read : zts_op_write;
          next_addr1 = bus.address;
          next_lanes1 = bus.byte_lane_write_n;
        end else begin
          next_active = 1'b0;  // [R04]
          next_op1 = zts_op_idle;
        end
      end else if (active) begin
        // advance: step the counter and rebuild the low bits
        next_count = count + 2'b01;  // [R07]
        if (bus.burst_order == `ZTS_ORDER_LINEAR) begin  // [R08]
          low_bits = base[1:0] + next_count;  // [R16]
        end else begin
          low_bits = base[1:0] ^ next_count;  // [R16]
        end
        cur_addr = {base[ADDR_W-1:2], low_bits};  // [R14]
        next_op1 = burst_write ? zts_op_write : zts_op_read;
        next_addr1 = cur_addr;
        next_lanes1 = bus.byte_lane_write_n;
      end else begin
        // advance with no burst running starts nothing
        next_op1 = zts_op_idle;
      end
    end
  end

  // merge a write that is in its data phase at the same address, so a
  // read loaded right behind that write sees the new word, not the old one
  always_comb begin
    fwd_word = mem[addr1];
    if (op2 == zts_op_write && addr2 == addr1) begin  // [R11]
      for (int i = 0; i < LANES; i++) begin
        if (!lanes2[i]) begin  // [R15]
          fwd_word[i*LANE_W +: LANE_W] = bus.dq[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // second stage, read output register and drive control
  always_comb begin
    next_op2 = op2;
    next_addr2 = addr2;
    next_lanes2 = lanes2;
    next_rdata = rdata;
    next_drive = drive;
    if (bus.clock_hold_n == 1'b0) begin  // [R03]
      // clock running: the data phase moves one stage on
      next_op2 = op1;
      next_addr2 = addr1;
      next_lanes2 = lanes1;
      // data phase two cycles after sampling, even after deselect
      next_drive = (op1 == zts_op_read);  // [R02] [R05] [R06]
      if (op1 == zts_op_read) begin
        next_rdata = fwd_word;  // [R12]
      end
    end
  end

  // state registers
  always_ff @(posedge bus.clock) begin
    if (!rst_b) begin
      base <= '0;
      count <= 2'b00;
      active <= 1'b0;
      burst_write <= 1'b0;
      op1 <= zts_op_idle;
      op2 <= zts_op_idle;
      addr1 <= '0;
      addr2 <= '0;
      lanes1 <= '1;
      lanes2 <= '1;
      rdata <= '0;
      drive <= 1'b0;
    end else begin
      base <= next_base;
      count <= next_count;
      active <= next_active;
      burst_write <= next_burst_write;
      op1 <= next_op1;
      op2 <= next_op2;
      addr1 <= next_addr1;
      addr2 <= next_addr2;
      lanes1 <= next_lanes1;
      lanes2 <= next_lanes2;
      rdata <= next_rdata;
      drive <= next_drive;
    end
  end

  // write data taken from the bus in the data phase
  always_ff @(posedge bus.clock) begin
    if (bus.clock_hold_n == 1'b0 && op2 == zts_op_write) begin  // [R02] [R03]
      // lanes held high keep their stored bytes
      for (int i = 0; i < LANES; i++) begin
        if (!lanes2[i]) begin  // [R15]
          mem[addr2][i*LANE_W +: LANE_W] <= bus.dq[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // registered data out; the enable pin cuts the drive at once
  assign bus.dq_from_mem = rdata;  // [R12]
  assign bus.dq_oe_mem = drive && !bus.output_drive_n;  // [R10]
  assign busy = active || op1 != zts_op_idle || op2 != zts_op_idle;
endmodule

// ===== hdl/zts_pkg.sv
package zts_pkg;
  // operation kind carried down the pipeline
  typedef enum logic [1:0] {
    zts_op_idle = 2'b00,
    zts_op_read = 2'b01,
    zts_op_write = 2'b10
  } zts_op_t;
  // master sequencer states
  typedef enum logic [1:0] {
    zts_st_idle = 2'b00,
    zts_st_burst = 2'b01
  } zts_state_t;
endpackage
